// [common/trx_pkg.sv]
// constants for the transmitter flag and receiver control registers
// assumes one 100 MHz clock and a host port that decodes register accesses
// Operation
// - finished user-to-transmit copy sets done flag when mask bit 0 is set
// - done flag drives interrupt and summary bit
// - slip or block start sets slip flag when mask bit 1 is set
// - select bit picks slip or block start
// - slip flag drives interrupt and summary bit
// - mask bit 0 enables done interrupt
// - mask bit 1 enables slip interrupt
// - mode bits 1:0 pick done trigger
// - mode bits 3:2 pick slip trigger
// - control bits 1:0 pick line receiver
// - control bit 3 picks reference clock
// - control bit 4 halts receive copies
// - control two bit 0 enables clock pin
// - divider field divides recovered clock 1/2/4/8
// - auto-mute zeroes audio when both unlocked
// - bit 4 stops or frees clock on unlock
// - pll byte holds pre-divider and multiplier high
// - status read-only, upper six bits zero
// - reference loop uses pre-divider and multiplier
// - transmit copy disable suspends user copies
package trx_pkg;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h0A;
  localparam logic [7:0] ADDR_TX_MASK = 8'h0B;
  localparam logic [7:0] ADDR_TX_MODE = 8'h0C;
  localparam logic [7:0] ADDR_RX_CTRL1 = 8'h0D;
  localparam logic [7:0] ADDR_RX_CTRL2 = 8'h0E;
  localparam logic [7:0] ADDR_PLL_CFG1 = 8'h0F;
  localparam int FLAG_XFER = 0;
  localparam int FLAG_SLIP = 1;
  localparam int MODE_XFER_LSB = 0;
  localparam int MODE_SLIP_LSB = 2;
  localparam int RX1_SEL_LSB = 0;
  localparam int RX1_REF = 3;
  localparam int RX1_COPY_DIS = 4;
  localparam int RX2_PIN_EN = 0;
  localparam int RX2_DIV_LSB = 1;
  localparam int RX2_MUTE = 3;
  localparam int RX2_LOL = 4;
  localparam int PLL_J_LSB = 0;
  localparam int PLL_P_LSB = 4;
  localparam logic [7:0] WMASK_TX_MASK = 8'h03;
  localparam logic [7:0] WMASK_TX_MODE = 8'h0F;
  localparam logic [7:0] WMASK_RX_CTRL1 = 8'h1B;
  localparam logic [7:0] WMASK_RX_CTRL2 = 8'h1F;
  localparam logic [7:0] WMASK_PLL_CFG1 = 8'hFF;
  localparam logic [7:0] RST_TX_MASK = 8'h00;
  localparam logic [7:0] RST_TX_MODE = 8'h00;
  localparam logic [7:0] RST_RX_CTRL1 = 8'h00;
  localparam logic [7:0] RST_RX_CTRL2 = 8'h00;
  localparam logic [7:0] RST_PLL_CFG1 = 8'h00;
  typedef enum logic [1:0] {
    TRIG_RISE,
    TRIG_FALL,
    TRIG_LEVEL,
    TRIG_RSVD
  } trx_trig_t;
endpackage : trx_pkg

// [common/trx_flag_if.sv]
// flag conditions, masks and trigger modes shared with the flag unit
// assumes both ends on the same clock
`timescale 1ns/10ps
interface trx_flag_if;
  logic [1:0] cond;
  logic [1:0] mask;
  logic [3:0] mode;
  logic clear;
  logic [1:0] flags;
  logic [1:0] next_flags;
  modport ctrl(output cond, output mask, output mode, output clear,
    input flags, input next_flags);
  modport unit(input cond, input mask, input mode, input clear,
    output flags, output next_flags);
endinterface : trx_flag_if

// [hw/trx_flag_unit.sv]
// sticky transmitter flags with per-flag trigger mode and mask
// assumes conditions come from logic on the same clock
`timescale 1ns/10ps
module trx_flag_unit (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // flag group
  trx_flag_if.unit fl
);
  logic [1:0] prev_cond;
  logic [1:0] hit;
  logic [1:0] next_prev_cond;
  logic [1:0] flags;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flag
      trx_pkg::trx_trig_t md;
      logic hit_one;
      assign md = trx_pkg::trx_trig_t'(fl.mode[2*gi +: 2]);
      always_comb begin
        case (md)
          trx_pkg::TRIG_RISE: hit_one = fl.cond[gi] & ~prev_cond[gi];
          trx_pkg::TRIG_FALL: hit_one = ~fl.cond[gi] & prev_cond[gi];
          trx_pkg::TRIG_LEVEL: hit_one = fl.cond[gi];
          default: hit_one = 1'b0;
        endcase
      end
      // one driver per bit keeps each flag's trigger in its own process
      assign hit[gi] = hit_one;
    end
  endgenerate

  always_comb begin
    next_prev_cond = fl.cond;
    // set wins over a clear in the same cycle
    fl.next_flags = (flags & ~{2{fl.clear}}) | (hit & fl.mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_cond <= 2'h0;
      flags <= 2'h0;
    end else begin
      prev_cond <= next_prev_cond;
      flags <= fl.next_flags;
    end
  end

  assign fl.flags = flags;

  property p_masked_stays;
    @(posedge clock) disable iff (rst)
    (fl.clear && fl.mask == 2'h0) |=> flags == 2'h0;
  endproperty
  a_masked_stays: assert property (p_masked_stays)
    else $error("masked flag set after clear");

  property p_level_sets;
    @(posedge clock) disable iff (rst)
    (fl.mode[3:2] == 2'h2 && fl.mask[1] && fl.cond[1]) |=> flags[1];
  endproperty
  a_level_sets: assert property (p_level_sets)
    else $error("level slip did not set flag");
endmodule : trx_flag_unit

// [hw/trx_regs.sv]
// registers 0x0A..0x0F: transmitter flags, receiver control, pll byte
// assumes the host port presents decoded one-cycle register strobes
`timescale 1ns/10ps
module trx_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port from the host interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // transmitter side
  input wire logic xfer_done,
  input wire logic async_slip,
  input wire logic block_start,
  input wire logic slip_source_select,
  input wire logic transmit_copy_disable,
  output logic transmit_copy_allow,
  output logic int_n,
  output logic tx_summary,
  // receiver side
  input wire logic [3:0] rx_line,
  output logic rx_core_data,
  output logic receiver_ref_select,
  output logic receive_copy_allow,
  output logic [3:0] pll_pre_divider,
  output logic [3:0] pll_multiplier_high,
  // recovered clock
  input wire logic loop_clock,
  input wire logic decoder_unlock,
  input wire logic loop_unlock,
  output logic recovered_clock_out,
  output logic recovered_clock_oe,
  // audio path
  input wire logic [23:0] audio_in,
  output logic [23:0] audio_out
);
  trx_flag_if fl();

  logic [7:0] tx_mask;
  logic [7:0] tx_mode;
  logic [7:0] rx_ctrl1;
  logic [7:0] rx_ctrl2;
  logic [7:0] pll_cfg1;
  logic [7:0] next_tx_mask;
  logic [7:0] next_tx_mode;
  logic [7:0] next_rx_ctrl1;
  logic [7:0] next_rx_ctrl2;
  logic [7:0] next_pll_cfg1;
  logic [7:0] next_reg_rdata;
  logic next_int_n;
  logic next_tx_summary;
  logic [3:0] rx_meta;
  logic [3:0] rx_sync;
  logic next_rx_core_data;
  logic loop_prev;
  logic [2:0] div_cnt;
  logic next_loop_prev;
  logic [2:0] next_div_cnt;
  logic next_clk_out;
  logic clock_stopped;
  logic mute;
  logic [23:0] next_audio_out;
  logic [1:0] div_sel;

  trx_flag_unit u_flags (
    .clock(clock),
    .rst(rst),
    .fl(fl.unit)
  );

  // flag conditions and controls into the flag unit
  always_comb begin
    fl.cond[trx_pkg::FLAG_XFER] = xfer_done & ~transmit_copy_disable;
    fl.cond[trx_pkg::FLAG_SLIP] = slip_source_select ? block_start
      : async_slip;
    fl.mask = tx_mask[1:0];
    fl.mode = tx_mode[3:0];
    fl.clear = reg_rd && reg_addr == trx_pkg::ADDR_TX_STATUS;
  end

  assign transmit_copy_allow = ~transmit_copy_disable;

  // register writes and reads
  always_comb begin
    next_tx_mask = tx_mask;
    next_tx_mode = tx_mode;
    next_rx_ctrl1 = rx_ctrl1;
    next_rx_ctrl2 = rx_ctrl2;
    next_pll_cfg1 = pll_cfg1;
    next_reg_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        trx_pkg::ADDR_TX_MASK:
          next_tx_mask = reg_wdata & trx_pkg::WMASK_TX_MASK;
        trx_pkg::ADDR_TX_MODE:
          next_tx_mode = reg_wdata & trx_pkg::WMASK_TX_MODE;
        trx_pkg::ADDR_RX_CTRL1:
          next_rx_ctrl1 = reg_wdata & trx_pkg::WMASK_RX_CTRL1;
        trx_pkg::ADDR_RX_CTRL2:
          next_rx_ctrl2 = reg_wdata & trx_pkg::WMASK_RX_CTRL2;
        trx_pkg::ADDR_PLL_CFG1:
          next_pll_cfg1 = reg_wdata & trx_pkg::WMASK_PLL_CFG1;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        trx_pkg::ADDR_TX_STATUS: next_reg_rdata = {6'h00, fl.flags};
        trx_pkg::ADDR_TX_MASK: next_reg_rdata = tx_mask;
        trx_pkg::ADDR_TX_MODE: next_reg_rdata = tx_mode;
        trx_pkg::ADDR_RX_CTRL1: next_reg_rdata = rx_ctrl1;
        trx_pkg::ADDR_RX_CTRL2: next_reg_rdata = rx_ctrl2;
        trx_pkg::ADDR_PLL_CFG1: next_reg_rdata = pll_cfg1;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_mask <= trx_pkg::RST_TX_MASK;
      tx_mode <= trx_pkg::RST_TX_MODE;
      rx_ctrl1 <= trx_pkg::RST_RX_CTRL1;
      rx_ctrl2 <= trx_pkg::RST_RX_CTRL2;
      pll_cfg1 <= trx_pkg::RST_PLL_CFG1;
      reg_rdata <= 8'h00;
    end else begin
      tx_mask <= next_tx_mask;
      tx_mode <= next_tx_mode;
      rx_ctrl1 <= next_rx_ctrl1;
      rx_ctrl2 <= next_rx_ctrl2;
      pll_cfg1 <= next_pll_cfg1;
      reg_rdata <= next_reg_rdata;
    end
  end

  // interrupt pin and summary bit follow the flags
  always_comb begin
    next_int_n = ~|fl.next_flags;
    next_tx_summary = |fl.next_flags;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      int_n <= 1'b1;
      tx_summary <= 1'b0;
    end else begin
      int_n <= next_int_n;
      tx_summary <= next_tx_summary;
    end
  end

  // receiver steering
  assign receiver_ref_select = rx_ctrl1[trx_pkg::RX1_REF];
  assign receive_copy_allow = ~rx_ctrl1[trx_pkg::RX1_COPY_DIS];
  assign pll_pre_divider = pll_cfg1[trx_pkg::PLL_P_LSB +: 4];
  assign pll_multiplier_high = pll_cfg1[trx_pkg::PLL_J_LSB +: 4];
  assign recovered_clock_oe = rx_ctrl2[trx_pkg::RX2_PIN_EN];

  // line receiver pins pass two flops before the input mux
  always_comb begin
    next_rx_core_data = rx_sync[rx_ctrl1[trx_pkg::RX1_SEL_LSB +: 2]];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_meta <= 4'h0;
      rx_sync <= 4'h0;
      rx_core_data <= 1'b0;
    end else begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
      rx_core_data <= next_rx_core_data;
    end
  end

  // recovered clock divider on the loop output
  assign div_sel = rx_ctrl2[trx_pkg::RX2_DIV_LSB +: 2];
  assign clock_stopped = loop_unlock & ~rx_ctrl2[trx_pkg::RX2_LOL];

  always_comb begin
    next_loop_prev = loop_clock;
    next_div_cnt = div_cnt;
    if (clock_stopped) begin
      next_clk_out = 1'b0;
    end else begin
      if (loop_clock && !loop_prev) begin
        next_div_cnt = div_cnt + 3'h1;
      end
      case (div_sel)
        2'h0: next_clk_out = loop_clock;
        2'h1: next_clk_out = next_div_cnt[0];
        2'h2: next_clk_out = next_div_cnt[1];
        default: next_clk_out = next_div_cnt[2];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      loop_prev <= 1'b0;
      div_cnt <= 3'h0;
      recovered_clock_out <= 1'b0;
    end else begin
      loop_prev <= next_loop_prev;
      div_cnt <= next_div_cnt;
      recovered_clock_out <= next_clk_out;
    end
  end

  // audio auto-mute on loss of lock
  assign mute = rx_ctrl2[trx_pkg::RX2_MUTE] & decoder_unlock & loop_unlock;

  always_comb begin
    next_audio_out = mute ? 24'h000000 : audio_in;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      audio_out <= 24'h000000;
    end else begin
      audio_out <= next_audio_out;
    end
  end

  property p_done_sets_flag;
    @(posedge clock) disable iff (rst)
    (xfer_done && !$past(xfer_done) && !transmit_copy_disable
      && tx_mask[0] && tx_mode[1:0] == 2'h0)
      |=> fl.flags[trx_pkg::FLAG_XFER];
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("finished copy did not set done flag");

  property p_disable_blocks;
    @(posedge clock) disable iff (rst)
    (transmit_copy_disable && !fl.flags[0] && !fl.cond[0])
      |=> !fl.flags[0];
  endproperty
  a_disable_blocks: assert property (p_disable_blocks)
    else $error("done flag set while copies disabled");

  property p_flag_int;
    @(posedge clock) disable iff (rst)
    (fl.flags != 2'h0) |-> (!int_n && tx_summary);
  endproperty
  a_flag_int: assert property (p_flag_int)
    else $error("flag set without interrupt and summary");

  property p_slip_int;
    @(posedge clock) disable iff (rst)
    $rose(fl.flags[1]) |-> !int_n;
  endproperty
  a_slip_int: assert property (p_slip_int)
    else $error("slip flag without interrupt low");

  property p_slip_src;
    @(posedge clock) disable iff (rst)
    (slip_source_select && block_start && tx_mask[1]
      && tx_mode[3:2] == 2'h2) |=> fl.flags[1];
  endproperty
  a_slip_src: assert property (p_slip_src)
    else $error("block start did not set slip flag");

  property p_status_read;
    @(posedge clock) disable iff (rst)
    (reg_rd && reg_addr == trx_pkg::ADDR_TX_STATUS)
      |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status upper bits not zero");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == trx_pkg::ADDR_RX_CTRL1)
      |=> (rx_ctrl1[7:5] == 3'h0 && rx_ctrl1[2] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits stored");

  property p_input_mux;
    @(posedge clock) disable iff (rst)
    $stable(rx_ctrl1[1:0]) |=> rx_core_data == $past(rx_sync[rx_ctrl1[1:0]]);
  endproperty
  a_input_mux: assert property (p_input_mux)
    else $error("wrong line receiver routed");

  property p_mute;
    @(posedge clock) disable iff (rst)
    mute |=> audio_out == 24'h000000;
  endproperty
  a_mute: assert property (p_mute)
    else $error("audio not muted on loss of lock");

  property p_clock_stop;
    @(posedge clock) disable iff (rst)
    clock_stopped [*2] |-> !recovered_clock_out;
  endproperty
  a_clock_stop: assert property (p_clock_stop)
    else $error("recovered clock ran while stopped");

  property p_pin_enable;
    @(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == trx_pkg::ADDR_RX_CTRL2)
      |=> recovered_clock_oe == $past(reg_wdata[0]);
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("clock pin enable not taken from write");
endmodule : trx_regs

// [bench/trx_loop_model.sv]
// far-side model: the recovered-clock loop seen by the register block
// assumes it shares the system clock; loop output changes on falling edges
`timescale 1ns/10ps
module trx_loop_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control from the bench
  input wire logic run,
  // loop output
  output logic loop_clock
);
  // output stands still whenever the loop is not running
  always @(negedge clock) begin
    if (rst) begin
      loop_clock <= 1'b0;
    end else if (run) begin
      loop_clock <= ~loop_clock;
    end
  end
endmodule : trx_loop_model

// [bench/trx_regs_bench.sv]
// self-checking bench for the transmitter flag and receiver control regs
// assumes the decoded strobe port, one cycle read latency, clear-on-read
`timescale 1ns/10ps
`define CHK(n, e, g) check_val(n, 24'(e), 24'(g));
module trx_regs_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic xfer_done = 1'b0, async_slip = 1'b0, block_start = 1'b0;
  logic slip_source_select = 1'b0, transmit_copy_disable = 1'b0;
  logic [3:0] rx_line = 4'h0;
  logic run = 1'b0, decoder_unlock = 1'b0, loop_unlock = 1'b0;
  logic [23:0] audio_in = 24'h000000, audio_out;
  logic transmit_copy_allow, int_n, tx_summary, rx_core_data;
  logic receiver_ref_select, receive_copy_allow, loop_clock;
  logic [3:0] pll_pre_divider, pll_multiplier_high;
  logic recovered_clock_out, recovered_clock_oe;
  int fail_count = 0, checked = 0, cycles = 0, n, e;
  logic [7:0] wr_exp [6] = '{8'h00, 8'h03, 8'h0F, 8'h1B, 8'h1F, 8'hFF};

  always #5 clock = ~clock;

  trx_loop_model loop_model (.clock(clock), .rst(rst), .run(run),
    .loop_clock(loop_clock));

  trx_regs DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xfer_done(xfer_done), .async_slip(async_slip),
    .block_start(block_start), .slip_source_select(slip_source_select),
    .transmit_copy_disable(transmit_copy_disable),
    .transmit_copy_allow(transmit_copy_allow), .int_n(int_n),
    .tx_summary(tx_summary), .rx_line(rx_line), .rx_core_data(rx_core_data),
    .receiver_ref_select(receiver_ref_select),
    .receive_copy_allow(receive_copy_allow),
    .pll_pre_divider(pll_pre_divider),
    .pll_multiplier_high(pll_multiplier_high), .loop_clock(loop_clock),
    .decoder_unlock(decoder_unlock), .loop_unlock(loop_unlock),
    .recovered_clock_out(recovered_clock_out),
    .recovered_clock_oe(recovered_clock_oe), .audio_in(audio_in),
    .audio_out(audio_out));

  task automatic check_val(input string nm, input logic [23:0] ex,
    input logic [23:0] got);
    checked++;
    if (got !== ex) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : check_val

  // all tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rdata;
    @(negedge clock);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(negedge clock);
  endtask : idle

  task automatic set_cond(input int w, input logic v);
    case (w)
      0: xfer_done = v;
      1: async_slip = v;
      default: block_start = v;
    endcase
  endtask : set_cond

  task automatic pulse_rd(input int w, input logic [7:0] ex);
    set_cond(w, 1'b1);
    idle(1);
    set_cond(w, 1'b0);
    idle(2);
    rd(8'h0A, d);
    `CHK("status", ex, d)
  endtask : pulse_rd

  task automatic count_rise(output int c);
    logic p;
    c = 0;
    p = recovered_clock_out;
    repeat (128) begin
      @(negedge clock);
      if (recovered_clock_out === 1'b1 && p === 1'b0) c++;
      p = recovered_clock_out;
    end
  endtask : count_rise

  task automatic stop_test;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'h0A + 8'(i), d);
      `CHK("reset value", 8'h00, d)
    end
    `CHK("idle int_n", 1'b1, int_n)
    for (int i = 0; i < 6; i++) begin
      wr(8'h0A + 8'(i), 8'hFF);
      rd(8'h0A + 8'(i), d);
      `CHK("masked readback", wr_exp[i], d)
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    `CHK("ref select", 1'b1, receiver_ref_select)
    `CHK("rx copy allow", 1'b0, receive_copy_allow)
    `CHK("clock pin oe", 1'b1, recovered_clock_oe)
    wr(8'h0F, 8'hA5);
    `CHK("pre divider", 4'hA, pll_pre_divider)
    `CHK("multiplier", 4'h5, pll_multiplier_high)
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h0B, 8'h00);
    `CHK("ref select", 1'b0, receiver_ref_select)
    `CHK("rx copy allow", 1'b1, receive_copy_allow)
    `CHK("clock pin oe", 1'b0, recovered_clock_oe)
    pulse_rd(0, 8'h00);
    wr(8'h0B, 8'h01);
    pulse_rd(1, 8'h00);
    wr(8'h0B, 8'h03);
    set_cond(0, 1'b1);
    idle(1);
    set_cond(0, 1'b0);
    idle(1);
    `CHK("int_n low", 1'b0, int_n)
    `CHK("summary", 1'b1, tx_summary)
    rd(8'h0A, d);
    `CHK("done flag", 8'h01, d)
    idle(1);
    `CHK("int_n released", 1'b1, int_n)
    transmit_copy_disable = 1'b1;
    pulse_rd(0, 8'h00);
    `CHK("tx copy allow", 1'b0, transmit_copy_allow)
    transmit_copy_disable = 1'b0;
    pulse_rd(1, 8'h02);
    slip_source_select = 1'b1;
    pulse_rd(1, 8'h00);
    pulse_rd(2, 8'h02);
    slip_source_select = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 4; m++) begin
        wr(8'h0C, 8'(m << (2 * f)));
        set_cond(f, 1'b1);
        idle(3);
        rd(8'h0A, d);
        `CHK("trig high", 8'((m == 0 || m == 2) << f), d)
        set_cond(f, 1'b0);
        idle(3);
        rd(8'h0A, d);
        `CHK("trig low", 8'((m == 1 || m == 2) << f), d)
        rd(8'h0A, d);
        `CHK("trig cleared", 8'h00, d)
      end
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h0D, 8'(s));
      rx_line = 4'(1 << s);
      idle(5);
      `CHK("rx select one", 1'b1, rx_core_data)
      rx_line = ~rx_line;
      idle(5);
      `CHK("rx select zero", 1'b0, rx_core_data)
    end
    run = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h0E, 8'(k << 1));
      idle(20);
      count_rise(n);
      e = 64 >> k;
      `CHK("divider", (n >= e - 1 && n <= e + 1), 1'b1)
    end
    loop_unlock = 1'b1;
    wr(8'h0E, 8'h02);
    idle(4);
    count_rise(n);
    `CHK("stopped clock", 0, n)
    wr(8'h0E, 8'h12);
    idle(20);
    count_rise(n);
    `CHK("free run", (n >= 31 && n <= 33), 1'b1)
    audio_in = 24'hA5C3F0;
    decoder_unlock = 1'b1;
    wr(8'h0E, 8'h00);
    idle(2);
    `CHK("no mute", 24'hA5C3F0, audio_out)
    wr(8'h0E, 8'h08);
    idle(2);
    `CHK("muted", 24'h000000, audio_out)
    decoder_unlock = 1'b0;
    idle(2);
    `CHK("one unlock", 24'hA5C3F0, audio_out)
    stop_test();
  end
endmodule : trx_regs_bench
